//--- src/event_capture_and_window_watchdog.sv
// event capture, rxd signalling, sleep guard and window supervisor
`timescale 1ns/1ps
`include "event_wd_regs.svh"
module event_capture_and_window_watchdog import event_wd_pkg::*; #(
  parameter int WD_TICK_CYCLES = `WD_TICK_CYCLES,
  parameter int EVENT_DELAY_CYCLES = `EVENT_DELAY_CYCLES,
  parameter logic [7:0] DEVICE_IDENTIFICATION = 8'hA5 // arbitrary value
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] sys_event,
  input wire logic [7:0] trx_event,
  input wire logic [1:0] wake_event,
  input wire logic io_supply,
  input wire logic trx_standby,
  output logic rxd_low,
  output logic inhibit_output,
  output logic discharge_active,
  output logic [1:0] device_mode
);
  localparam int TICK_W = $clog2(WD_TICK_CYCLES);
  localparam int DLY_W = $clog2(EVENT_DELAY_CYCLES + 1);

  // supervisor base period in ms, zero for a redundant code that is invalid
  function automatic logic [12:0] period_ms(input logic [3:0] c);
    case (c)
      4'h8: period_ms = 13'h0008;
      4'h1: period_ms = 13'h0010;
      4'h2: period_ms = 13'h0020;
      4'hB: period_ms = 13'h0040;
      4'h4: period_ms = 13'h0080;
      4'hD: period_ms = 13'h0100;
      4'hE: period_ms = 13'h0400;
      4'h7: period_ms = 13'h1000;
      default: period_ms = 13'h0000;
    endcase
  endfunction

  // host reset length in half-ms ticks, taken at the lower bound
  function automatic logic [8:0] reset_ticks(input logic [3:0] c);
    case (c)
      4'h8: reset_ticks = 9'h002;
      4'h1: reset_ticks = 9'h008;
      4'h2: reset_ticks = 9'h014;
      4'hB: reset_ticks = 9'h028;
      4'h4: reset_ticks = 9'h050;
      4'hD: reset_ticks = 9'h078;
      4'hE: reset_ticks = 9'h0C8;
      4'h7: reset_ticks = 9'h12C;
      default: reset_ticks = 9'h000;
    endcase
  endfunction

  // twice the prescale factor, so half-ms ticks count the period exactly
  function automatic logic [2:0] prescale_x2(input logic [1:0] p);
    case (p)
      2'h0: prescale_x2 = 3'h2;
      2'h1: prescale_x2 = 3'h3;
      2'h2: prescale_x2 = 3'h5;
      default: prescale_x2 = 3'h7;
    endcase
  endfunction

  // write-one-to-clear update where a new event beats the clear
  function automatic logic [7:0] w1c(input logic [7:0] cur,
                                     input logic [7:0] clr,
                                     input logic [7:0] set);
    w1c = (cur & ~clr) | set;
  endfunction

  logic rst_meta_n; // reset release stage one
  logic rst_sync_n; // released reset used by everything else
  logic [7:0] sys_en; // system capture enables
  logic [7:0] trx_en; // transceiver capture enables
  logic [7:0] wake_en; // wake pin capture enables
  logic [7:0] lock_ctrl; // write protection per section
  logic [7:0] wd_cfg1; // supervisor mode, prescale, option bits
  logic [7:0] wd_cfg2; // supervisor period and reset length codes
  logic [7:0] wd_flags; // sticky supervisor status flags
  logic [7:0] sys_st; // system event status
  logic [7:0] trx_st; // transceiver event status
  logic [7:0] wake_st; // wake pin event status
  dev_mode_t mode; // current device mode
  dev_mode_t next_mode; // device mode for the next cycle
  logic [15:0] wd_cnt; // supervisor timer in half-ms ticks
  logic [8:0] rst_cnt; // host reset duration counter
  logic long_open; // long open window after inhibit rise
  logic [TICK_W-1:0] tick_div; // half-ms tick divider
  logic [DLY_W-1:0] delay_cnt; // event delay timer

  // reset is released through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // register write decode; locked sections refuse host writes
  wire wr_en_ok = reg_wr && !lock_ctrl[`LOCK_ENABLES_BIT];
  wire wr_st_ok = reg_wr && !lock_ctrl[`LOCK_STATUS_BIT];
  wire wr_sys_en = wr_en_ok && reg_addr == `OFF_SYS_EN;
  wire wr_trx_en = wr_en_ok && reg_addr == `OFF_TRX_EN;
  wire wr_wake_en = wr_en_ok && reg_addr == `OFF_WAKE_EN;
  wire wr_lock = reg_wr && reg_addr == `OFF_LOCK;
  wire mode_wr = reg_wr && reg_addr == `OFF_MODE;
  wire stat_wr = reg_wr && reg_addr == `OFF_WD_STAT;

  // event capture; power-on and frame error need no enable
  wire [7:0] sys_cap = sys_event & (sys_en | `SYS_ALWAYS_MASK);
  wire [7:0] trx_cap = trx_event & trx_en;
  wire [7:0] wake_cap = {6'h00, wake_event} & wake_en;
  wire any_cap = |{sys_cap, trx_cap, wake_cap};

  // host clear masks, one per status register
  wire [7:0] sys_clr = (wr_st_ok && reg_addr == `OFF_SYS_ST) ?
                       reg_wdata : 8'h00;
  wire [7:0] trx_clr = (wr_st_ok && reg_addr == `OFF_TRX_ST) ?
                       reg_wdata : 8'h00;
  wire [7:0] wake_clr = (wr_st_ok && reg_addr == `OFF_WAKE_ST) ?
                        reg_wdata : 8'h00;
  wire cleared_any = |{sys_clr & sys_st, trx_clr & trx_st,
                       wake_clr & wake_st};
  wire pending = |{sys_st, trx_st, wake_st};
  wire [7:0] summary = {4'h0, |wake_st, 1'b0, |trx_st, |sys_st};

  // sleep allowed only with a regular wake source and nothing pending
  wire wake_src = trx_en[`TRX_CAN_WAKE_BIT] || |(wake_en & `WAKE_REG_MASK);
  wire sleep_ok = wake_src && !pending && !any_cap;

  // supervisor configuration decode with redundant code check
  wire wd_cfg_wr = reg_wr && (reg_addr == `OFF_WD_CFG1 ||
                              reg_addr == `OFF_WD_CFG2);
  wire cfg1_ok = reg_wdata[7:5] == WD_OFF || reg_wdata[7:5] == WD_TIMEOUT ||
                 reg_wdata[7:5] == WD_WINDOW;
  wire cfg2_ok = period_ms(reg_wdata[7:4]) != 13'h0000 &&
                 reset_ticks(reg_wdata[3:0]) != 9'h000;
  wire code_ok = (reg_addr == `OFF_WD_CFG1) ? cfg1_ok : cfg2_ok;
  wire wd_illegal = wd_cfg_wr && mode != DEV_STANDBY;
  wire wd_apply = wd_cfg_wr && !wd_illegal && code_ok;
  wire wd_corrupt = wd_cfg_wr && !wd_illegal && !code_ok;

  // supervisor period in half-ms ticks, stretched by the prescaler
  wire [15:0] wd_limit = {3'h0, period_ms(wd_cfg2[7:4])} *
                         {13'h0000, prescale_x2(wd_cfg1[4:3])};
  wire [15:0] wd_half = {1'b0, wd_limit[15:1]};
  wire wd_on = wd_cfg1[7:5] != WD_OFF;
  // window checks apply only in normal mode, else time-out behaviour
  wire wd_window = wd_cfg1[7:5] == WD_WINDOW && mode == DEV_NORMAL &&
                   !long_open;
  wire wd_run = wd_on && mode != DEV_RESET &&
                (mode != DEV_SLEEP || wd_cfg1[`WD_SLEEP_BIT]);
  wire tick = tick_div == TICK_W'(WD_TICK_CYCLES - 1);
  wire trig_wr = reg_wr && reg_addr == `OFF_WD_TRIG &&
                 reg_wdata == `WD_TRIG_PATTERN;
  wire wd_early = trig_wr && wd_run && wd_window && wd_cnt < wd_half;
  wire trig_ok = trig_wr && wd_run && !wd_early;
  wire wd_overflow = tick && wd_run && wd_cnt + 16'h0001 >= wd_limit;
  wire wd_fail = wd_early || wd_overflow || wd_illegal;
  wire reset_done = tick && rst_cnt + 9'h001 >= reset_ticks(wd_cfg2[3:0]);
  wire inhibit_rise = (mode == DEV_SLEEP || mode == DEV_RESET) &&
                      next_mode == DEV_STANDBY;
  wire sleep_entry = mode != DEV_SLEEP && next_mode == DEV_SLEEP;
  wire [7:0] wd_set = {1'b0, wd_corrupt, wd_illegal, 1'b0,
                       wd_overflow && mode != DEV_SLEEP,
                       wd_overflow && mode == DEV_SLEEP, wd_early, 1'b0};
  wire [7:0] wd_stat = {!wd_on, wd_flags[6:5],
                        wd_window && wd_cnt < wd_half, wd_flags[3:0]};

  // mode sequencing: supervisor reset first, then wake, then host request
  always_comb begin
    next_mode = mode;
    if (wd_fail) begin
      next_mode = DEV_RESET;
    end else if (mode == DEV_RESET) begin
      if (reset_done) begin
        next_mode = DEV_STANDBY;
      end
    end else if (mode == DEV_SLEEP && any_cap) begin
      next_mode = DEV_STANDBY;
    end else if (mode_wr) begin
      unique case (reg_wdata[2:0])
        `MODE_CODE_SLEEP: next_mode = sleep_ok ? DEV_SLEEP : DEV_STANDBY;
        `MODE_CODE_STANDBY: next_mode = DEV_STANDBY;
        `MODE_CODE_NORMAL: next_mode = DEV_NORMAL;
        default: next_mode = mode;
      endcase
    end
  end

  // host-written control registers
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sys_en <= 8'h00;
      trx_en <= 8'h00;
      wake_en <= 8'h00;
      lock_ctrl <= 8'h00;
      wd_cfg1 <= `WD_CFG1_RESET;
      wd_cfg2 <= `WD_CFG2_RESET;
    end else begin
      if (wr_sys_en) sys_en <= reg_wdata;
      if (wr_trx_en) trx_en <= reg_wdata;
      if (wr_wake_en) wake_en <= reg_wdata & `WAKE_REG_MASK;
      if (wr_lock) lock_ctrl <= reg_wdata;
      if (wd_apply && reg_addr == `OFF_WD_CFG1) wd_cfg1 <= reg_wdata;
      if (wd_apply && reg_addr == `OFF_WD_CFG2) wd_cfg2 <= reg_wdata;
    end
  end

  // sticky status; device sets win over host clears, also when locked
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sys_st <= 8'h00;
      trx_st <= 8'h00;
      wake_st <= 8'h00;
      wd_flags <= 8'h00;
    end else begin
      sys_st <= w1c(sys_st, sys_clr, sys_cap);
      trx_st <= w1c(trx_st, trx_clr, trx_cap);
      wake_st <= w1c(wake_st, wake_clr, wake_cap);
      wd_flags <= w1c(wd_flags, stat_wr ? reg_wdata & `WD_W1C_MASK : 8'h00,
                      wd_set);
    end
  end

  // mode, reset length counter and tick divider
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mode <= DEV_STANDBY;
      rst_cnt <= 9'h000;
      tick_div <= '0;
    end else begin
      mode <= next_mode;
      rst_cnt <= (mode != DEV_RESET) ? 9'h000 : rst_cnt + {8'h00, tick};
      tick_div <= tick ? '0 : tick_div + 1'b1;
    end
  end

  // supervisor timer: restarted by trigger, config write, sleep, wake
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wd_cnt <= 16'h0000;
      long_open <= 1'b0;
    end else begin
      if (trig_ok || wd_apply || wd_fail || sleep_entry || inhibit_rise ||
          !wd_run) begin
        wd_cnt <= 16'h0000;
      end else if (tick) begin
        wd_cnt <= wd_cnt + 16'h0001;
      end
      if (inhibit_rise) begin
        long_open <= wd_cfg1[`WD_LONGWIN_BIT];
      end else if (trig_ok || wd_apply) begin
        long_open <= 1'b0;
      end
    end
  end

  // event delay timer and rxd flag
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      delay_cnt <= '0;
      rxd_low <= 1'b0;
    end else begin
      if (cleared_any) begin
        delay_cnt <= DLY_W'(EVENT_DELAY_CYCLES);
      end else if (delay_cnt != '0) begin
        delay_cnt <= delay_cnt - 1'b1;
      end
      rxd_low <= (trx_standby || mode == DEV_STANDBY) && io_supply &&
                 pending && delay_cnt == '0;
    end
  end

  // read data mux, registered
  wire [7:0] rd_mux =
    (reg_addr == `OFF_MODE) ? {5'h00, (mode == DEV_NORMAL) ?
      `MODE_CODE_NORMAL : (mode == DEV_SLEEP) ? `MODE_CODE_SLEEP :
      `MODE_CODE_STANDBY} :
    (reg_addr == `OFF_SYS_EN) ? sys_en :
    (reg_addr == `OFF_LOCK) ? lock_ctrl :
    (reg_addr == `OFF_TRX_EN) ? trx_en :
    (reg_addr == `OFF_WD_CFG1) ? wd_cfg1 :
    (reg_addr == `OFF_WD_CFG2) ? wd_cfg2 :
    (reg_addr == `OFF_WD_STAT) ? wd_stat :
    (reg_addr == `OFF_WAKE_EN) ? wake_en :
    (reg_addr == `OFF_SUMMARY) ? summary :
    (reg_addr == `OFF_SYS_ST) ? sys_st :
    (reg_addr == `OFF_TRX_ST) ? trx_st :
    (reg_addr == `OFF_WAKE_ST) ? wake_st :
    (reg_addr == `OFF_DEV_ID) ? DEVICE_IDENTIFICATION : 8'h00;

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) reg_rdata <= 8'h00;
    else reg_rdata <= rd_mux;
  end

  // inhibit off in sleep and during host reset
  assign inhibit_output = mode != DEV_SLEEP && mode != DEV_RESET;
  assign discharge_active = mode == DEV_RESET && wd_cfg1[`WD_DISCH_BIT];
  assign device_mode = mode;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_n);

  sequence s_sys_clear;
    reg_wr && reg_addr == `OFF_SYS_ST && !lock_ctrl[`LOCK_STATUS_BIT] &&
    reg_wdata[`SYS_POWER_ON_BIT] && !sys_cap[`SYS_POWER_ON_BIT];
  endsequence
  sequence s_release;
    delay_cnt != '0 ##1 !rxd_low;
  endsequence

  a_power_on_capture: assert property (
    sys_event[`SYS_POWER_ON_BIT] |=> sys_st[`SYS_POWER_ON_BIT])
    else $error("power-on event not captured");
  a_enabled_capture: assert property (
    trx_event[0] && trx_en[0] |=> trx_st[0])
    else $error("enabled event not captured");
  a_status_w1c: assert property (
    s_sys_clear |=> !sys_st[`SYS_POWER_ON_BIT])
    else $error("status bit not cleared by write one");
  a_clear_release: assert property (
    cleared_any |=> s_release)
    else $error("clear did not start delay and release rxd");
  a_rxd_pending: assert property (
    delay_cnt == '0 && pending && io_supply && mode == DEV_STANDBY &&
    !cleared_any |=> rxd_low)
    else $error("rxd not low with pending event");
  a_sleep_guard: assert property (
    mode_wr && reg_wdata[2:0] == `MODE_CODE_SLEEP && !sleep_ok &&
    !wd_fail && mode != DEV_RESET && mode != DEV_SLEEP
    |=> mode == DEV_STANDBY)
    else $error("sleep entered without guard");
  a_sleep_wake: assert property (
    mode == DEV_SLEEP && any_cap && !wd_fail
    |=> mode == DEV_STANDBY && inhibit_output)
    else $error("event in sleep did not wake");
  a_illegal_cfg: assert property (
    wd_illegal |=> mode == DEV_RESET && !inhibit_output &&
    wd_flags[`WD_ILLCONF_BIT])
    else $error("illegal config did not reset host");
  a_corrupt_keep: assert property (
    wd_corrupt |=> wd_flags[`WD_CORRUPTED_ACCESS_FLAG_BIT] && $stable(wd_cfg1) &&
    $stable(wd_cfg2))
    else $error("corrupt config not abandoned");
  a_trigger_restart: assert property (
    trig_ok && !wd_fail |=> wd_cnt == 16'h0000)
    else $error("trigger did not restart timer");
  a_id_read: assert property (
    reg_addr == `OFF_DEV_ID |=> reg_rdata == DEVICE_IDENTIFICATION)
    else $error("identification byte wrong");
endmodule

//--- src/event_wd_regs.svh
// register offsets, field layouts, codes and timing of the event supervisor
`ifndef EVENT_WD_REGS_SVH
`define EVENT_WD_REGS_SVH
// Functional notes
// - power-on and frame-error events always captured
// - enabled event sets its status bit
// - standby with io supply: event pulls rxd low
// - sleep event: inhibit high, standby, rxd low
// - enabled event in standby or sleep wakes
// - global summary shows which group captured
// - write one clears status, zero keeps
// - clearing releases rxd, starts delay timer
// - delay expiry re-asserts rxd if pending
// - sleep needs wake source and clear status
// - read-only identification byte at fixed address
// - locked bits refuse host writes, device updates
// - supervisor resets host by inhibit off
// - mode field: off, time-out, window
// - window mode: trigger in window restarts
// - time-out mode: trigger anytime restarts timer
// - config write restarts timer, applies at once
// - window outside normal runs as time-out
// - config outside standby: reset, illegal flag
// - prescale stretches period 1, 1.5, 2.5, 3.5
// - run-in-sleep, long window, discharge bits
// - trigger pattern write restarts the timer
// - invalid config code abandoned, corrupt flag
// register offsets (7-bit register address)
`define OFF_MODE 7'h01
`define OFF_SYS_EN 7'h04
`define OFF_LOCK 7'h0A
`define OFF_TRX_EN 7'h23
`define OFF_WD_CFG1 7'h36
`define OFF_WD_CFG2 7'h37
`define OFF_WD_STAT 7'h38
`define OFF_WD_TRIG 7'h39
`define OFF_WAKE_EN 7'h4C
`define OFF_SUMMARY 7'h60
`define OFF_SYS_ST 7'h61
`define OFF_TRX_ST 7'h63
`define OFF_WAKE_ST 7'h64
`define OFF_DEV_ID 7'h7E
// event field layout
`define SYS_ALWAYS_MASK 8'h30
`define SYS_POWER_ON_BIT 4
`define TRX_CAN_WAKE_BIT 0
`define WAKE_REG_MASK 8'h03
`define SUM_SYS_BIT 0
`define SUM_TRX_BIT 1
`define SUM_WAKE_BIT 3
`define LOCK_ENABLES_BIT 0
`define LOCK_STATUS_BIT 1
// supervisor configuration one layout and reset
`define WD_SLEEP_BIT 2
`define WD_LONGWIN_BIT 1
`define WD_DISCH_BIT 0
`define WD_CFG1_RESET 8'h22
`define WD_CFG2_RESET 8'h47
// supervisor status layout
`define WD_OFF_BIT 7
`define WD_CORRUPTED_ACCESS_FLAG_BIT 6
`define WD_ILLCONF_BIT 5
`define WD_TRIGS_BIT 4
`define WD_W1C_MASK 8'h6E
`define WD_TRIG_PATTERN 8'h55
// device mode codes
`define MODE_CODE_SLEEP 3'h1
`define MODE_CODE_STANDBY 3'h4
`define MODE_CODE_NORMAL 3'h7
// timing
`define CLK_PERIOD_NS 50
`define WD_TICK_US 500
`define WD_TICK_CYCLES ((`WD_TICK_US * 1000) / `CLK_PERIOD_NS)
`define EVENT_DELAY_US 100
`define EVENT_DELAY_CYCLES ((`EVENT_DELAY_US * 1000) / `CLK_PERIOD_NS)
`endif

//--- src/event_wd_pkg.sv
// types shared by the event capture and supervisor logic
package event_wd_pkg;
  // device operating mode
  typedef enum logic [1:0] {
    DEV_STANDBY = 2'h0,
    DEV_NORMAL = 2'h1,
    DEV_SLEEP = 2'h3,
    DEV_RESET = 2'h2
  } dev_mode_t;
  // supervisor mode field codes (redundant, two bits apart)
  typedef enum logic [2:0] {
    WD_OFF = 3'h1,
    WD_TIMEOUT = 3'h2,
    WD_WINDOW = 3'h4
  } wd_mode_t;
endpackage

//--- tb/host_model.sv
// host microcontroller model driving the register port of the block
`timescale 1ns/1ps
`include "event_wd_regs.svh"
module host_model (
  input wire logic clk,
  output logic reg_wr,
  output logic [6:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  // idle bus from time zero
  initial begin
    reg_wr = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 8'h00;
  end
  // one write, launched just after an edge, held for one edge
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    #2;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk);
    #2;
    reg_wr = 1'b0;
    reg_wdata = ~d; // no stale data left behind
  endtask
  // read: data stands one edge after the address
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk);
    #2;
    reg_addr = a;
    @(posedge clk);
    #2;
    d = reg_rdata;
  endtask
  // clear only what the last read showed as set
  task automatic ack(input logic [6:0] a);
    logic [7:0] seen;
    rd(a, seen);
    wr(a, seen);
  endtask
  // period first, then mode; used only in standby
  task automatic wd_cfg(input logic [7:0] c2, input logic [7:0] c1);
    wr(`OFF_WD_CFG2, c2);
    wr(`OFF_WD_CFG1, c1);
  endtask
endmodule

//--- tb/event_capture_and_window_watchdog_tb_top.sv
// self-checking bench for event capture and supervisor
`timescale 1ns/1ps
`include "event_wd_regs.svh"
module event_capture_and_window_watchdog_tb_top;
  localparam logic [7:0] ID = 8'h3C; // arbitrary identification value
  localparam int TICK = 4; // shortened supervisor tick
  localparam int EDLY = 8; // shortened event delay
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [7:0] sys_event = 8'h00;
  logic [7:0] trx_event = 8'h00;
  logic [1:0] wake_event = 2'h0;
  logic io_supply = 1'b1;
  logic trx_standby = 1'b0;
  logic rxd_low;
  logic inhibit_output;
  logic discharge_active;
  logic [1:0] device_mode;
  int err_total = 0;
  int n_checks = 0;
  int n; // cycles spent in the last wait
  // 20 MHz clock
  always #25 clk = ~clk;
  host_model u_host (.clk(clk), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  event_capture_and_window_watchdog #(.WD_TICK_CYCLES(TICK),
    .EVENT_DELAY_CYCLES(EDLY), .DEVICE_IDENTIFICATION(ID)) u_dut (.clk(clk),
    .rst_n(rst_n), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sys_event(sys_event),
    .trx_event(trx_event), .wake_event(wake_event), .io_supply(io_supply),
    .trx_standby(trx_standby), .rxd_low(rxd_low),
    .inhibit_output(inhibit_output), .discharge_active(discharge_active),
    .device_mode(device_mode));
  // verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // byte compare
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // pin compare
  task automatic chk_pin(input logic got, input logic exp);
    chk({7'h0, got}, {7'h0, exp});
  endtask
  // register read compare
  task automatic chk_rd(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_host.rd(a, d);
    chk(d, exp);
  endtask
  // let cycles pass, end just after an edge
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask
  // one-cycle event pulse
  task automatic ev(input logic [7:0] s, input logic [7:0] t,
    input logic [1:0] w);
    @(posedge clk);
    #2;
    sys_event = s;
    trx_event = t;
    wake_event = w;
    @(posedge clk);
    #2;
    sys_event = 8'h00;
    trx_event = 8'h00;
    wake_event = 2'h0;
  endtask
  // bounded wait on rxd (pin=1) or device mode (pin=0)
  task automatic wait_for(input logic [7:0] exp, input logic pin,
    input int lim, output int k);
    logic [7:0] cur;
    for (k = 0; k < lim; k++) begin
      cur = pin ? {7'h0, rxd_low} : {6'h0, device_mode};
      if (cur === exp) break;
      cyc(1);
    end
    chk(cur, exp);
    if (cur !== exp) tally_and_finish();
  endtask
  // reset values, identification, then a clean start
  task automatic s_reset();
    chk_pin(inhibit_output, 1'b1);
    chk({6'h0, device_mode}, 8'h00);
    chk_rd(`OFF_DEV_ID, ID);
    u_host.wr(`OFF_DEV_ID, ~ID);
    chk_rd(`OFF_DEV_ID, ID);
    chk_rd(`OFF_WD_CFG1, 8'h22);
    chk_rd(7'h10, 8'h00);
    u_host.wr(`OFF_SYS_ST, 8'hFF);
    u_host.wr(`OFF_TRX_ST, 8'hFF);
    u_host.wr(`OFF_WAKE_ST, 8'hFF);
    u_host.wr(`OFF_WD_STAT, 8'hFF);
    u_host.wr(`OFF_SYS_EN, 8'h00);
    u_host.wr(`OFF_TRX_EN, 8'h00);
    u_host.wr(`OFF_WAKE_EN, 8'h00);
    cyc(2 * EDLY);
    chk_pin(rxd_low, 1'b0);
    chk_rd(`OFF_SUMMARY, 8'h00);
    chk_rd(`OFF_WD_STAT, 8'h80);
  endtask
  // always-captured events versus disabled ones
  task automatic s_capture();
    ev(8'h00, 8'h01, 2'h0);
    cyc(3);
    chk_rd(`OFF_TRX_ST, 8'h00);
    chk_pin(rxd_low, 1'b0);
    ev(8'h30, 8'h00, 2'h0);
    cyc(1);
    chk_pin(rxd_low, 1'b1);
    chk_rd(`OFF_SYS_ST, 8'h30);
    chk_rd(`OFF_SUMMARY, 8'h01);
    u_host.wr(`OFF_SYS_ST, 8'h00);
    chk_rd(`OFF_SYS_ST, 8'h30);
    chk_pin(rxd_low, 1'b1);
  endtask
  // clear releases rxd, events batch until the delay ends
  task automatic s_delay();
    u_host.wr(`OFF_WAKE_EN, 8'h03);
    u_host.wr(`OFF_SYS_ST, 8'h30);
    cyc(1);
    chk_pin(rxd_low, 1'b0);
    ev(8'h00, 8'h00, 2'h2);
    chk_pin(rxd_low, 1'b0);
    wait_for(8'h01, 1'b1, 3 * EDLY, n);
    chk({7'h0, n >= 3}, 8'h01);
    chk_rd(`OFF_WAKE_ST, 8'h02);
    chk_rd(`OFF_SUMMARY, 8'h08);
    chk_rd(`OFF_SYS_ST, 8'h00);
    u_host.ack(`OFF_WAKE_ST);
    cyc(3 * EDLY);
    chk_pin(rxd_low, 1'b0);
  endtask
  // locked sections refuse host writes, device still sets status
  task automatic s_lock();
    u_host.wr(`OFF_LOCK, 8'h03);
    u_host.wr(`OFF_WAKE_EN, 8'h00);
    chk_rd(`OFF_WAKE_EN, 8'h03);
    ev(8'h00, 8'h00, 2'h1);
    u_host.wr(`OFF_WAKE_ST, 8'hFF);
    chk_rd(`OFF_WAKE_ST, 8'h01);
    u_host.wr(`OFF_LOCK, 8'h00);
    u_host.ack(`OFF_WAKE_ST);
    cyc(3 * EDLY);
  endtask
  // sleep guard, then a wake from sleep
  task automatic s_sleep();
    ev(8'h00, 8'h00, 2'h1);
    u_host.wr(`OFF_MODE, 8'h01);
    cyc(2);
    chk({6'h0, device_mode}, 8'h00);
    u_host.ack(`OFF_WAKE_ST);
    u_host.wr(`OFF_WAKE_EN, 8'h00);
    u_host.wr(`OFF_MODE, 8'h01);
    cyc(2);
    chk({6'h0, device_mode}, 8'h00);
    u_host.wr(`OFF_WAKE_EN, 8'h03);
    cyc(3 * EDLY);
    u_host.wr(`OFF_MODE, 8'h01);
    cyc(2);
    chk({6'h0, device_mode}, 8'h03);
    chk_pin(inhibit_output, 1'b0);
    ev(8'h00, 8'h00, 2'h2);
    cyc(2);
    chk({6'h0, device_mode}, 8'h00);
    chk_pin(inhibit_output, 1'b1);
    chk_pin(rxd_low, 1'b1);
    u_host.ack(`OFF_WAKE_ST);
  endtask
  // bad code, time-out mode with triggers, prescale stretch
  task automatic s_wd_time();
    u_host.wr(`OFF_WD_CFG1, 8'h62);
    chk_rd(`OFF_WD_CFG1, 8'h22);
    chk_rd(`OFF_WD_STAT, 8'hC0);
    u_host.wr(`OFF_WD_STAT, 8'h40);
    u_host.wd_cfg(8'h47, 8'h42);
    repeat (3) begin
      cyc(600);
      u_host.wr(`OFF_WD_TRIG, 8'h55);
    end
    cyc(600);
    u_host.wd_cfg(8'h47, 8'h42);
    cyc(600);
    chk({6'h0, device_mode}, 8'h00);
    wait_for(8'h02, 1'b0, 600, n);
    chk_pin(inhibit_output, 1'b0);
    wait_for(8'h00, 1'b0, 1400, n);
    chk({7'h0, n >= 1100}, 8'h01);
    chk_rd(`OFF_WD_STAT, 8'h08);
    u_host.wd_cfg(8'h47, 8'h4A);
    cyc(1300);
    chk({6'h0, device_mode}, 8'h00);
    wait_for(8'h02, 1'b0, 400, n);
    wait_for(8'h00, 1'b0, 1400, n);
    u_host.wd_cfg(8'h47, 8'h23);
    u_host.wr(`OFF_WD_STAT, 8'hFF);
  endtask
  // configuration outside standby resets the host
  task automatic s_wd_illegal();
    u_host.wr(`OFF_MODE, 8'h07);
    cyc(2);
    chk({6'h0, device_mode}, 8'h01);
    u_host.wr(`OFF_WD_CFG1, 8'h23);
    wait_for(8'h02, 1'b0, 4, n);
    chk_pin(inhibit_output, 1'b0);
    chk_pin(discharge_active, 1'b1);
    wait_for(8'h00, 1'b0, 1400, n);
    chk_rd(`OFF_WD_STAT, 8'hA0);
  endtask
  // window mode: time-out outside normal, early trigger resets host
  task automatic s_wd_window();
    u_host.wr(`OFF_WD_STAT, 8'hFF);
    u_host.wd_cfg(8'h88, 8'h80);
    u_host.wr(`OFF_WD_TRIG, 8'h55);
    cyc(2);
    chk({6'h0, device_mode}, 8'h00);
    u_host.wr(`OFF_MODE, 8'h07);
    cyc(40);
    u_host.wr(`OFF_WD_TRIG, 8'h55);
    chk_rd(`OFF_WD_STAT, 8'h10);
    u_host.wr(`OFF_WD_TRIG, 8'h55);
    wait_for(8'h02, 1'b0, 4, n);
    chk_pin(discharge_active, 1'b0);
    wait_for(8'h00, 1'b0, 40, n);
    chk_rd(`OFF_WD_STAT, 8'h02);
    u_host.wd_cfg(8'h47, 8'h22);
  endtask
  // rxd flag needs io supply; transceiver standby flags in normal mode
  task automatic s_rxd_gate();
    io_supply = 1'b0;
    ev(8'h00, 8'h00, 2'h2);
    cyc(2);
    chk_pin(rxd_low, 1'b0);
    io_supply = 1'b1;
    cyc(2);
    chk_pin(rxd_low, 1'b1);
    u_host.ack(`OFF_WAKE_ST);
    u_host.wr(`OFF_MODE, 8'h07);
    cyc(3 * EDLY);
    ev(8'h00, 8'h00, 2'h1);
    cyc(2);
    chk_pin(rxd_low, 1'b0);
    trx_standby = 1'b1;
    cyc(2);
    chk_pin(rxd_low, 1'b1);
    trx_standby = 1'b0;
    u_host.ack(`OFF_WAKE_ST);
    u_host.wr(`OFF_MODE, 8'h04);
    cyc(3 * EDLY);
  endtask
  // main sequence
  initial begin
    cyc(6);
    rst_n = 1'b1;
    cyc(6);
    s_reset();
    s_capture();
    s_delay();
    s_lock();
    s_sleep();
    s_wd_time();
    s_wd_illegal();
    s_wd_window();
    s_rxd_gate();
    tally_and_finish();
  end
endmodule
